// [core/sepr_pkg.sv]
// Shared constants and carriers of the system-option and EEPROM block-guard registers.
// Assumes one 250 MHz clock in which each clock cycle counts as one E-clock cycle.
package sepr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] BLOCK_GUARD_ADDR   = 16'h1035; // eeprom_block_guard
  localparam logic [15:0] SETUP_OPTIONS_ADDR = 16'h1039; // system_setup_options

  // ----------------------------------------------------------------
  // Field positions of system_setup_options
  // ----------------------------------------------------------------
  localparam int OPT_ADC_BIT  = 7;  // analog_converter_power_up
  localparam int OPT_PUMP_BIT = 6;  // charge_pump_clock_select
  localparam int OPT_EDGE_BIT = 5;  // interrupt_edge_mode
  localparam int OPT_WAIT_BIT = 4;  // stop_exit_delay_enable
  localparam int OPT_CMON_BIT = 3;  // clock_monitor_enable
  localparam int OPT_RATE_HI  = 1;  // watchdog_rate_select upper bit
  localparam int OPT_RATE_LO  = 0;  // watchdog_rate_select lower bit

  // Field positions of eeprom_block_guard
  localparam int GUARD_SETUP_BIT = 4; // setup_register_protect
  localparam int GUARD_NUM_BLK   = 4; // eeprom_block_protect_bits width

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPT_RESET   = 8'h10; // Only the stop-exit delay bit is set
  localparam logic [4:0] GUARD_RESET = 5'h1f; // All five protect bits set

  // ----------------------------------------------------------------
  // Timing, in E-clock cycles, and derived clock counts
  // ----------------------------------------------------------------
  localparam int ECLK_PER_CLK       = 1;    // One E-clock cycle per clk cycle
  localparam int WINDOW_ECLK        = 64;   // Write window after reset
  localparam int STOP_SLOW_ECLK     = 4000; // Oscillator startup delay
  localparam int STOP_FAST_ECLK     = 4;    // Bypassed delay, about four cycles
  localparam logic [6:0]  WINDOW_CYC    = 7'(WINDOW_ECLK * ECLK_PER_CLK);
  localparam logic [11:0] STOP_SLOW_CYC = 12'(STOP_SLOW_ECLK * ECLK_PER_CLK);
  localparam logic [11:0] STOP_FAST_CYC = 12'(STOP_FAST_ECLK * ECLK_PER_CLK);
  localparam int WDOG_PRESCALE      = 32768; // Two to the fifteenth

  // ----------------------------------------------------------------
  // EEPROM address map, one base and last address per protected block
  // ----------------------------------------------------------------
  localparam logic [15:0] EE_FIRST = 16'hb600;
  localparam logic [15:0] EE_LAST  = 16'hb7ff;
  localparam logic [63:0] BLK_BASE = {16'hb6e0, 16'hb660, 16'hb620, 16'hb600};
  localparam logic [63:0] BLK_LAST = {16'hb7ff, 16'hb6df, 16'hb65f, 16'hb61f};

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;  // Register address
    logic [7:0]  wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } sepr_bus_req_t;

  typedef struct packed {
    logic [15:0] addr;   // Target EEPROM address
    logic        setup;  // Target is the nonvolatile configuration register
    logic        valid;  // One-cycle check request
  } sepr_prog_req_t;

  typedef enum logic [1:0] {
    SEPR_RUN,
    SEPR_HALT,
    SEPR_WAKE
  } sepr_stop_t;

endpackage

// [core/sepr_regs.sv]
// System-option and EEPROM block-guard register bank with its steering logic.
// Assumes a single-cycle register port on clk, a mode pin and an interrupt pin
// from outside the clock domain, and same-domain stop and program-check requests.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns

// Operation
// - Timed option bits take one write only in normal mode
// - Normal mode: that write within 64 cycles
// - Edge-mode bit picks level or edge interrupt
// - Delay bit clear: resume within four cycles
// - Delay bit set: wait 4000 cycles, resets one
// - Option bit 2 ignores writes, reads zero
// - Watchdog prescale two to fifteen, rate scales
// - Clock-select bit switches pump and converter clock
// - Protect bits reset one, clear early only
// - Protect bits may be set anytime
// - Special modes lift the protect window
// - Setup-protect bit blocks config programming
// - Block-protect bit blocks its EEPROM block
// - Blocks zero, one: 32 and 64 bytes
// - Blocks two, three: 128 and 288 bytes
// - Guard bits 7 to 5 read zero
// - EEPROM mapped only while enable bit set
module sepr_regs #(
  parameter int WDOG_PRESCALE = sepr_pkg::WDOG_PRESCALE // Shorten for simulation
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire sepr_pkg::sepr_bus_req_t  bus_req,
  output logic [7:0]                    bus_rdata_ff,
  input  wire logic                     special_mode_pin,
  input  wire logic                     irq_pin_n,
  input  wire logic                     irq_ack,
  input  wire logic                     stop_enter,
  input  wire logic                     eeprom_visible_enable,
  input  wire sepr_pkg::sepr_prog_req_t prog_req,
  output logic                          prog_done_ff,
  output logic                          prog_allowed_ff,
  output logic                          eeprom_mapped_ff,
  output logic                          irq_request_ff,
  output logic                          halted_ff,
  output logic                          stop_resume_ff,
  output logic                          watchdog_tick_ff,
  output logic                          analog_converter_power_up_ff,
  output logic                          charge_pump_clock_select_ff,
  output logic                          clock_monitor_enable_ff
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]  mode_sync_ff;     // Mode pin synchroniser
  logic [1:0]  irq_sync_ff;      // Interrupt pin synchroniser
  logic        irq_prev_n_ff;    // Last synchronised pin level
  logic [6:0]  win_cnt_ff;       // Cycles since reset, saturates
  logic        opt_locked_ff;    // Timed option bits already written
  logic        irq_edge_ff;      // interrupt_edge_mode
  logic        stop_wait_ff;     // stop_exit_delay_enable
  logic [1:0]  wdog_rate_ff;     // watchdog_rate_select
  logic        setup_prot_ff;    // setup_register_protect
  logic [3:0]  blk_prot_ff;      // eeprom_block_protect_bits
  sepr_pkg::sepr_stop_t stop_state_ff;
  logic [11:0] stop_cnt_ff;      // Remaining wake delay
  logic [15:0] pre_cnt_ff;       // Watchdog prescaler
  logic [5:0]  rate_cnt_ff;      // Watchdog rate scaler
  logic        special_mode;     // Synchronised special mode
  logic        window_open;      // Inside the early write window
  logic        wr_opt;           // Write to system_setup_options
  logic        wr_guard;         // Write to eeprom_block_guard
  logic        timed_ok;         // Timed option bits accept this write
  logic        irq_level;        // Synchronised pin is asserted
  logic [3:0]  blk_hit;          // Address falls in each block
  logic        nxt_allowed;      // Program check result
  logic [4:0]  nxt_guard;        // Next protect bits
  logic [5:0]  rate_limit;       // Rate scaler terminal count
  logic [7:0]  opt_view;         // Read view of the option register

  assign special_mode = mode_sync_ff[1];
  assign irq_level    = ~irq_sync_ff[1];
  assign window_open  = win_cnt_ff < sepr_pkg::WINDOW_CYC;
  assign wr_opt       = bus_req.wr && (bus_req.addr == sepr_pkg::SETUP_OPTIONS_ADDR);
  assign wr_guard     = bus_req.wr && (bus_req.addr == sepr_pkg::BLOCK_GUARD_ADDR);
  // Special modes always open; normal modes need window and no earlier write
  assign timed_ok     = special_mode || (window_open && !opt_locked_ff);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin; only the second stage is read by logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_sync_ff <= 2'h0;
      irq_sync_ff  <= 2'h3;
    end
    else
    begin
      mode_sync_ff <= {mode_sync_ff[0], special_mode_pin};
      irq_sync_ff  <= {irq_sync_ff[0], irq_pin_n};
    end
  end

  // ----------------------------------------------------------------
  // Early write window
  // ----------------------------------------------------------------
  // Counts cycles from reset release and holds at the window length
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      win_cnt_ff <= 7'h00;
    else if (window_open)
      win_cnt_ff <= win_cnt_ff + 7'h01;
  end

  // ----------------------------------------------------------------
  // System setup options
  // ----------------------------------------------------------------
  // Freely writable bits; bit 2 has no storage at all
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      analog_converter_power_up_ff <= sepr_pkg::OPT_RESET[sepr_pkg::OPT_ADC_BIT];
      charge_pump_clock_select_ff  <= sepr_pkg::OPT_RESET[sepr_pkg::OPT_PUMP_BIT];
      clock_monitor_enable_ff      <= sepr_pkg::OPT_RESET[sepr_pkg::OPT_CMON_BIT];
    end
    else if (wr_opt)
    begin
      analog_converter_power_up_ff <= bus_req.wdata[sepr_pkg::OPT_ADC_BIT];
      // Pump and converter both follow this select downstream
      charge_pump_clock_select_ff  <= bus_req.wdata[sepr_pkg::OPT_PUMP_BIT];
      clock_monitor_enable_ff      <= bus_req.wdata[sepr_pkg::OPT_CMON_BIT];
    end
  end

  // Timed bits: a refused write simply leaves them, the bus never errs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_edge_ff   <= sepr_pkg::OPT_RESET[sepr_pkg::OPT_EDGE_BIT];
      stop_wait_ff  <= sepr_pkg::OPT_RESET[sepr_pkg::OPT_WAIT_BIT];
      wdog_rate_ff  <= sepr_pkg::OPT_RESET[sepr_pkg::OPT_RATE_HI:sepr_pkg::OPT_RATE_LO];
      opt_locked_ff <= 1'b0;
    end
    else if (wr_opt && timed_ok)
    begin
      irq_edge_ff   <= bus_req.wdata[sepr_pkg::OPT_EDGE_BIT];
      stop_wait_ff  <= bus_req.wdata[sepr_pkg::OPT_WAIT_BIT];
      wdog_rate_ff  <= bus_req.wdata[sepr_pkg::OPT_RATE_HI:sepr_pkg::OPT_RATE_LO];
      opt_locked_ff <= 1'b1; // Counts in special modes too; unused there
    end
  end

  // ----------------------------------------------------------------
  // EEPROM block guard
  // ----------------------------------------------------------------
  // Clearing needs the window or a special mode; setting is always allowed
  always_comb
  begin
    if (special_mode || window_open)
      nxt_guard = bus_req.wdata[4:0];
    else
      nxt_guard = {setup_prot_ff, blk_prot_ff} | bus_req.wdata[4:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      setup_prot_ff <= sepr_pkg::GUARD_RESET[sepr_pkg::GUARD_SETUP_BIT];
      blk_prot_ff   <= sepr_pkg::GUARD_RESET[3:0];
    end
    else if (wr_guard)
    begin
      setup_prot_ff <= nxt_guard[sepr_pkg::GUARD_SETUP_BIT];
      blk_prot_ff   <= nxt_guard[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  assign opt_view = {analog_converter_power_up_ff, charge_pump_clock_select_ff,
                     irq_edge_ff, stop_wait_ff, clock_monitor_enable_ff,
                     1'b0, wdog_rate_ff};

  // Data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bus_rdata_ff <= 8'h00;
    else if (bus_req.rd && bus_req.addr == sepr_pkg::SETUP_OPTIONS_ADDR)
      bus_rdata_ff <= opt_view;
    else if (bus_req.rd && bus_req.addr == sepr_pkg::BLOCK_GUARD_ADDR)
      bus_rdata_ff <= {3'h0, setup_prot_ff, blk_prot_ff};
    else
      bus_rdata_ff <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Program and erase permission
  // ----------------------------------------------------------------
  // One comparator pair per protected block
  genvar gi;
  generate
    for (gi = 0; gi < sepr_pkg::GUARD_NUM_BLK; gi++)
    begin : g_blk
      assign blk_hit[gi] = (prog_req.addr >= sepr_pkg::BLK_BASE[gi*16 +: 16]) &&
                           (prog_req.addr <= sepr_pkg::BLK_LAST[gi*16 +: 16]);
    end
  endgenerate

  always_comb
  begin
    if (prog_req.setup)
      nxt_allowed = !setup_prot_ff;
    else
      nxt_allowed = eeprom_visible_enable && |(blk_hit & ~blk_prot_ff);
  end

  // Answer each check one cycle later
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_done_ff     <= 1'b0;
      prog_allowed_ff  <= 1'b0;
      eeprom_mapped_ff <= 1'b0;
    end
    else
    begin
      prog_done_ff     <= prog_req.valid;
      prog_allowed_ff  <= prog_req.valid && nxt_allowed;
      // Array appears in the map only with its enable bit set
      eeprom_mapped_ff <= eeprom_visible_enable &&
                          prog_req.addr >= sepr_pkg::EE_FIRST &&
                          prog_req.addr <= sepr_pkg::EE_LAST;
    end
  end

  // ----------------------------------------------------------------
  // External interrupt request
  // ----------------------------------------------------------------
  // Level mode follows the pin; edge mode latches a falling edge until acked
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_prev_n_ff  <= 1'b1;
      irq_request_ff <= 1'b0;
    end
    else
    begin
      irq_prev_n_ff <= irq_sync_ff[1];
      if (!irq_edge_ff)
        irq_request_ff <= irq_level;
      else if (irq_prev_n_ff && irq_level)
        irq_request_ff <= 1'b1; // New edge wins over an ack
      else if (irq_ack)
        irq_request_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Stop exit sequencing
  // ----------------------------------------------------------------
  // Halt until an interrupt request, then wait the selected delay
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stop_state_ff  <= sepr_pkg::SEPR_RUN;
      stop_cnt_ff    <= 12'h000;
      halted_ff      <= 1'b0;
      stop_resume_ff <= 1'b0;
    end
    else
    begin
      stop_resume_ff <= 1'b0;
      case (stop_state_ff)
        sepr_pkg::SEPR_RUN:
        begin
          if (stop_enter)
          begin
            stop_state_ff <= sepr_pkg::SEPR_HALT;
            halted_ff     <= 1'b1;
          end
        end
        sepr_pkg::SEPR_HALT:
        begin
          if (irq_request_ff)
          begin
            stop_state_ff <= sepr_pkg::SEPR_WAKE;
            // Delay bit chosen at wake time; counter ends at one
            stop_cnt_ff <= stop_wait_ff ? sepr_pkg::STOP_SLOW_CYC - 12'h001
                                       : sepr_pkg::STOP_FAST_CYC - 12'h001;
          end
        end
        sepr_pkg::SEPR_WAKE:
        begin
          if (stop_cnt_ff == 12'h001)
          begin
            stop_state_ff  <= sepr_pkg::SEPR_RUN;
            halted_ff      <= 1'b0;
            stop_resume_ff <= 1'b1;
          end
          stop_cnt_ff <= stop_cnt_ff - 12'h001;
        end
        default:
        begin
          stop_state_ff <= sepr_pkg::SEPR_RUN;
          halted_ff     <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Watchdog time base
  // ----------------------------------------------------------------
  // Rate scale of 1, 4, 16 or 64 prescaled periods
  always_comb
  begin
    case (wdog_rate_ff)
      2'h0:    rate_limit = 6'h00;
      2'h1:    rate_limit = 6'h03;
      2'h2:    rate_limit = 6'h0f;
      default: rate_limit = 6'h3f;
    endcase
  end

  // Prescaler wraps every two to the fifteen cycles, then the rate scaler
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_cnt_ff       <= 16'h0000;
      rate_cnt_ff      <= 6'h00;
      watchdog_tick_ff <= 1'b0;
    end
    else
    begin
      watchdog_tick_ff <= 1'b0;
      if (pre_cnt_ff == 16'(WDOG_PRESCALE - 1))
      begin
        pre_cnt_ff <= 16'h0000;
        if (rate_cnt_ff >= rate_limit)
        begin
          rate_cnt_ff      <= 6'h00;
          watchdog_tick_ff <= 1'b1;
        end
        else
          rate_cnt_ff <= rate_cnt_ff + 6'h01;
      end
      else
        pre_cnt_ff <= pre_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [11:0] wake_len_ff; // Cycles spent waking, for the exit checks
  logic        wake_wait_ff; // Delay bit seen at wake entry

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_len_ff <= 12'h000;
      wake_wait_ff <= 1'b0;
    end
    else if (stop_state_ff == sepr_pkg::SEPR_WAKE)
      wake_len_ff <= wake_len_ff + 12'h001;
    else
    begin
      wake_len_ff <= 12'h000;
      wake_wait_ff <= stop_wait_ff;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  opt_once_a: assert property (
    wr_opt && opt_locked_ff && !special_mode |=>
      $stable({irq_edge_ff, stop_wait_ff, wdog_rate_ff}))
    else $error("timed option bits changed after their single write");

  opt_window_a: assert property (
    wr_opt && !window_open && !special_mode |=> $stable(wdog_rate_ff) && $stable(irq_edge_ff))
    else $error("timed option bits written after the window");

  irq_level_a: assert property (
    !irq_edge_ff && irq_level |=> irq_request_ff)
    else $error("level interrupt not requested");

  fast_exit_a: assert property (
    stop_resume_ff && !wake_wait_ff |-> wake_len_ff == sepr_pkg::STOP_FAST_CYC - 12'h001)
    else $error("fast stop exit length wrong");

  slow_exit_a: assert property (
    stop_resume_ff && wake_wait_ff |-> wake_len_ff == sepr_pkg::STOP_SLOW_CYC - 12'h001)
    else $error("slow stop exit length wrong");

  bit_two_a: assert property (
    $past(bus_req.rd && bus_req.addr == sepr_pkg::SETUP_OPTIONS_ADDR) |-> !bus_rdata_ff[2])
    else $error("option bit 2 read nonzero");

  guard_clear_a: assert property (
    wr_guard && !window_open && !special_mode |=>
      (blk_prot_ff & $past(blk_prot_ff)) == $past(blk_prot_ff))
    else $error("protect bit cleared after the window");

  guard_set_a: assert property (
    wr_guard |=> (blk_prot_ff & $past(bus_req.wdata[3:0])) == $past(bus_req.wdata[3:0]))
    else $error("protect bit not set by write");

  blk_deny_a: assert property (
    prog_req.valid && !prog_req.setup && ((blk_hit & blk_prot_ff) == blk_hit) |=> !prog_allowed_ff)
    else $error("protected block granted");

endmodule

// [tb/sepr_regs_bench.sv]
// Self-checking bench for the option and block-guard register bank.
// Assumes the bank alone on one 250 MHz clock, every input driven from here.
`timescale 1ns/1ns
module sepr_regs_bench;
  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam int          WDP = 8;                            // Short prescale keeps runs brief
  localparam logic [15:0] OPT = sepr_pkg::SETUP_OPTIONS_ADDR; // Option register
  localparam logic [15:0] GRD = sepr_pkg::BLOCK_GUARD_ADDR;   // Guard register
  logic                     clk, reset_n, mode, irq_n, ack, stp, ee_en;
  sepr_pkg::sepr_bus_req_t  bus_req;
  sepr_pkg::sepr_prog_req_t prog_req;
  logic [7:0]               rdata, v;
  logic                     done, allowed, mapped, irq, halted, resume, tick, adc_on, pump_sel, clk_mon;
  int                       bad_count, samples_checked, seed, n;
  logic [15:0]              edges [10] = '{16'hb600, 16'hb61f, 16'hb620, 16'hb65f, 16'hb660,
                                           16'hb6df, 16'hb6e0, 16'hb7ff, 16'hb5ff, 16'hb800};

  sepr_regs #(.WDOG_PRESCALE(WDP)) uut (
    .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata_ff(rdata),
    .special_mode_pin(mode), .irq_pin_n(irq_n), .irq_ack(ack), .stop_enter(stp),
    .eeprom_visible_enable(ee_en), .prog_req(prog_req), .prog_done_ff(done),
    .prog_allowed_ff(allowed), .eeprom_mapped_ff(mapped), .irq_request_ff(irq),
    .halted_ff(halted), .stop_resume_ff(resume), .watchdog_tick_ff(tick),
    .analog_converter_power_up_ff(adc_on), .charge_pump_clock_select_ff(pump_sel),
    .clock_monitor_enable_ff(clk_mon));

  // ----------------------------------------------------------------
  // Shared tasks and the expectation function
  // ----------------------------------------------------------------
  // Verdict and end of run, reached by the main sequence or the watchdog
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Single comparison for every kind of result, zero-extended to 16 bits
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reset held for 20 cycles with the mode pin settled beforehand
  task automatic rst(input logic m);
    mode    <= m;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // One-cycle read; data only stands in the following cycle, so look there
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 cmp(rdata, e);
  endtask
  // Permission expected from the guard bits and the block boundaries
  function automatic logic allow(input logic [15:0] a, input logic c, input logic [4:0] g);
    if (c)
      return !g[4];
    if (!ee_en || a < 16'hb600 || a > 16'hb7ff)
      return 1'b0;
    if (a <= 16'hb61f)
      return !g[0];
    if (a <= 16'hb65f)
      return !g[1];
    if (a <= 16'hb6df)
      return !g[2];
    return !g[3];
  endfunction
  // One program-permission check, answer one cycle later
  task automatic pchk(input logic [15:0] a, input logic c, input logic [4:0] g);
    @(posedge clk);
    prog_req <= {a, c, 1'b1};
    @(posedge clk);
    prog_req.valid <= 1'b0;
    #1 cmp({done, allowed}, {1'b1, allow(a, c, g)});
    cmp(mapped, ee_en && a >= 16'hb600 && a <= 16'hb7ff);
  endtask
  // Block boundaries, the setup register, then random addresses near the array
  task automatic sweep(input logic [4:0] g);
    foreach (edges[i])
      pchk(edges[i], 1'b0, g);
    pchk(16'h0000, 1'b1, g);
    repeat (4)
      pchk(16'hb5f0 + 16'($random(seed) & 32'h0000_023f), 1'b0, g);
  endtask
  // Halt, wake by a level interrupt, measure the wake delay
  task automatic stopc(input int lo, input int hi);
    @(posedge clk);
    stp <= 1'b1;
    @(posedge clk);
    stp   <= 1'b0;
    irq_n <= 1'b0;
    #1 cmp(halted, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    cmp(16'(n), 16'h0003);
    n = 0;
    while (resume !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1 n++;
    end
    cmp(n >= lo && n <= hi, 1'b1);
    cmp(halted, 1'b0);
    @(posedge clk);
    irq_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 cmp(irq, 1'b0);
  endtask
  // Count edges until the next watchdog pulse
  task automatic tk;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (tick !== 1'b1 && n < 2000);
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang past about 50000 cycles counts as a mismatch
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset_n, mode, ack, stp} = 4'h0;
    {irq_n, ee_en} = 2'b11;
    bus_req = '0;
    prog_req = '0;
    seed = 23;
    bad_count = 0;
    samples_checked = 0;
    // Normal mode: reset values, unmapped space, write-once option bits
    rst(1'b0);
    rdc(OPT, 8'h10);
    rdc(GRD, 8'h1f);
    wr(16'h1036, 8'hff);
    rdc(16'h1036, 8'h00);
    pchk(16'hb600, 1'b0, 5'h1f);
    wr(OPT, 8'hff);
    rdc(OPT, 8'hfb);
    cmp({adc_on, pump_sel, clk_mon}, 3'b111);
    wr(OPT, 8'h00);
    rdc(OPT, 8'h33);
    cmp({adc_on, pump_sel, clk_mon}, 3'b000);
    // Guard cleared early, then set again at will
    wr(GRD, 8'h00);
    rdc(GRD, 8'h00);
    sweep(5'h00);
    wr(GRD, 8'h05);
    rdc(GRD, 8'h05);
    sweep(5'h05);
    repeat (70) @(posedge clk);
    wr(GRD, 8'h00);
    rdc(GRD, 8'h05);
    wr(GRD, 8'hff);
    rdc(GRD, 8'h1f);
    ee_en <= 1'b0;
    pchk(16'hb700, 1'b0, 5'h1f);
    pchk(16'h0000, 1'b1, 5'h1f);
    ee_en <= 1'b1;
    // Option write after the window: only untimed bits move
    rst(1'b0);
    repeat (70) @(posedge clk);
    wr(OPT, 8'heb);
    rdc(OPT, 8'hd8);
    // Special mode: no window, repeated writes
    rst(1'b1);
    repeat (70) @(posedge clk);
    repeat (6)
    begin
      v = 8'($random(seed));
      wr(GRD, v);
      rdc(GRD, v & 8'h1f);
    end
    wr(OPT, 8'h00);
    rdc(OPT, 8'h00);
    stopc(3, 6);
    wr(OPT, 8'h10);
    rdc(OPT, 8'h10);
    stopc(3999, 4002);
    // Watchdog periods for every rate setting
    for (int r = 0; r < 4; r++)
    begin
      wr(OPT, 8'(r));
      tk();
      tk();
      cmp(16'(n), 16'(WDP << (2 * r)));
    end
    // Edge mode: a short pulse latches until acknowledged
    wr(OPT, 8'h20);
    @(posedge clk);
    irq_n <= 1'b0;
    @(posedge clk);
    irq_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1 cmp(irq, 1'b1);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp(irq, 1'b0);
    final_report();
  end
endmodule
